// [common/wael_regs.vh]
// Register map, field positions and timing constants of the alert and event logic
`ifndef WAEL_REGS_VH
`define WAEL_REGS_VH

`define WAEL_ADDR_SCAN_CFG      8'h10
`define WAEL_ADDR_SCAN_EN       8'h12
`define WAEL_ADDR_NOTIFY_MASK   8'h14
`define WAEL_ADDR_CRC_MAP       8'h16
`define WAEL_ADDR_OUT_CFG       8'h17
`define WAEL_ADDR_STATUS        8'h18
`define WAEL_ADDR_UPPER_FLAGS   8'h1A
`define WAEL_ADDR_LOWER_FLAGS   8'h1C

`define WAEL_RESET_VALUE        8'h00
`define WAEL_SCAN_GO_BIT        4
`define WAEL_SCAN_STYLE_AUTO    2'h1
`define WAEL_CRC_EN_BIT         0
`define WAEL_OUT_CH_MSB         7
`define WAEL_OUT_CH_LSB         4
`define WAEL_STYLE_ACT_LOW      2'h0
`define WAEL_STYLE_ACT_HIGH     2'h1
`define WAEL_STYLE_PULSE_LOW    2'h2
`define WAEL_STYLE_PULSE_HIGH   2'h3

`define WAEL_CLK_PERIOD_NS      4
`define WAEL_PULSE_NS           1000
`define WAEL_PULSE_CYCLES       (`WAEL_PULSE_NS / `WAEL_CLK_PERIOD_NS)

`endif

// [hw/wael_pulse.v]
// Fixed-length pulse generator for the pulsed alert styles
`timescale 1ns/1ps
`include "wael_regs.vh"
module wael_pulse (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       rst_n,
    // Trigger and pulse
    input  wire       trigger,
    output reg        pulse_active
);
    localparam integer PULSE_FULL = `WAEL_PULSE_CYCLES;
    localparam [7:0]   PULSE_LEN  = PULSE_FULL[7:0];
    reg [7:0] count;

    // ==========================================
    // Pulse counter
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count        <= 8'h00;
            pulse_active <= 1'b0;
        end else if (trigger) begin
            count        <= PULSE_LEN - 8'h01;
            pulse_active <= 1'b1;
        end else if (count != 8'h00) begin
            count <= count - 8'h01;
        end else begin
            pulse_active <= 1'b0;
        end
    end
endmodule

// [hw/wael_top.v]
// Alert routing, event flags and scan selection registers
`timescale 1ns/1ps
`include "wael_regs.vh"
module wael_top (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       reset_n,
    // Register access from the serial decoder
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // Comparator events and CRC checker
    input  wire [7:0] high_event_in,
    input  wire [7:0] low_event_in,
    input  wire       input_crc_error_flag,
    // Digital input pins and their configuration
    input  wire [7:0] gpio_pin_in,
    input  wire [7:0] pin_is_digital_in,
    // Sequencer
    input  wire       scan_step,
    output reg        scan_run,
    output reg  [7:0] scan_channel_enable_mask,
    output reg  [2:0] scan_channel,
    // Alert output channel
    output reg  [7:0] alert_gpio_sel,
    output reg  [7:0] alert_gpio_out,
    output reg        alert_internal
);
    reg       rst_meta;
    reg       rst_n;
    reg [7:0] gpio_meta;
    reg [7:0] gpio_sync;
    reg [7:0] gpio_prev;
    reg [2:0] edge_primed;
    reg [1:0] scan_style_field;
    reg       scan_go_bit;
    reg [7:0] notify_channel_mask_bits;
    reg       crc_error_notify_enable;
    reg [3:0] out_channel;
    reg [1:0] out_style;
    reg [7:0] upper_event_flags;
    reg [7:0] lower_event_flags;
    reg [7:0] masked_prev;
    reg       crc_prev;
    wire [7:0] window_event_status;
    wire [7:0] masked_status;
    wire       crc_alert;
    wire       next_alert;
    wire       new_alert;
    wire       pulse_active;
    wire [7:0] rise_edge;
    wire [7:0] fall_edge;
    wire [7:0] upper_clear;
    wire [7:0] lower_clear;
    reg        next_pin_level;

    // Next enabled channel above the current one, wrapping around
    function [2:0] next_scan_ch;
        input [7:0] mask;
        input [2:0] cur;
        integer     i;
        reg   [2:0] pick;
        reg         found;
        reg   [2:0] idx;
        begin
            pick  = cur;
            found = 1'b0;
            for (i = 1; i <= 8; i = i + 1) begin
                idx = cur + i[2:0];
                if (!found && mask[idx]) begin
                    pick  = idx;
                    found = 1'b1;
                end
            end
            next_scan_ch = pick;
        end
    endfunction

    // ==========================================
    // Reset release and pin synchronisers
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gpio_meta <= 8'h00;
            gpio_sync <= 8'h00;
            gpio_prev <= 8'h00;
            edge_primed <= 3'h0;
        end else begin
            gpio_meta <= gpio_pin_in;
            gpio_sync <= gpio_meta;
            gpio_prev <= gpio_sync;
            edge_primed <= {edge_primed[1:0], 1'b1};
        end
    end

    // No edges until the history holds real pin levels
    assign rise_edge = gpio_sync & ~gpio_prev & pin_is_digital_in & {8{edge_primed[2]}};
    assign fall_edge = ~gpio_sync & gpio_prev & pin_is_digital_in & {8{edge_primed[2]}};

    // ==========================================
    // Register writes
    assign upper_clear = (reg_wr && reg_addr == `WAEL_ADDR_UPPER_FLAGS) ? reg_wdata : 8'h00;
    assign lower_clear = (reg_wr && reg_addr == `WAEL_ADDR_LOWER_FLAGS) ? reg_wdata : 8'h00;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_style_field         <= 2'h0;
            scan_go_bit              <= 1'b0;
            scan_channel_enable_mask <= `WAEL_RESET_VALUE;
            notify_channel_mask_bits <= `WAEL_RESET_VALUE;
            crc_error_notify_enable  <= 1'b0;
            out_channel              <= 4'h0;
            out_style                <= 2'h0;
            upper_event_flags        <= `WAEL_RESET_VALUE;
            lower_event_flags        <= `WAEL_RESET_VALUE;
        end else begin
            if (reg_wr) begin
                if (reg_addr == `WAEL_ADDR_SCAN_CFG) begin
                    scan_go_bit      <= reg_wdata[`WAEL_SCAN_GO_BIT];
                    scan_style_field <= reg_wdata[1:0];
                end else if (reg_addr == `WAEL_ADDR_SCAN_EN) begin
                    scan_channel_enable_mask <= reg_wdata;
                end else if (reg_addr == `WAEL_ADDR_NOTIFY_MASK) begin
                    notify_channel_mask_bits <= reg_wdata;
                end else if (reg_addr == `WAEL_ADDR_CRC_MAP) begin
                    crc_error_notify_enable <= reg_wdata[`WAEL_CRC_EN_BIT];
                end else if (reg_addr == `WAEL_ADDR_OUT_CFG) begin
                    out_channel <= reg_wdata[`WAEL_OUT_CH_MSB:`WAEL_OUT_CH_LSB];
                    out_style   <= reg_wdata[1:0];
                end
            end
            // Set wins over a same-cycle clear
            upper_event_flags <= (upper_event_flags & ~upper_clear)
                                 | high_event_in | rise_edge;
            lower_event_flags <= (lower_event_flags & ~lower_clear)
                                 | low_event_in | fall_edge;
        end
    end

    // ==========================================
    // Register reads
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `WAEL_ADDR_SCAN_CFG) begin
                reg_rdata <= {3'h0, scan_go_bit, 2'h0, scan_style_field};
            end else if (reg_addr == `WAEL_ADDR_SCAN_EN) begin
                reg_rdata <= scan_channel_enable_mask;
            end else if (reg_addr == `WAEL_ADDR_NOTIFY_MASK) begin
                reg_rdata <= notify_channel_mask_bits;
            end else if (reg_addr == `WAEL_ADDR_CRC_MAP) begin
                reg_rdata <= {7'h00, crc_error_notify_enable};
            end else if (reg_addr == `WAEL_ADDR_OUT_CFG) begin
                reg_rdata <= {out_channel, 2'h0, out_style};
            end else if (reg_addr == `WAEL_ADDR_STATUS) begin
                reg_rdata <= window_event_status;
            end else if (reg_addr == `WAEL_ADDR_UPPER_FLAGS) begin
                reg_rdata <= upper_event_flags;
            end else if (reg_addr == `WAEL_ADDR_LOWER_FLAGS) begin
                reg_rdata <= lower_event_flags;
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // ==========================================
    // Event status and alert combine
    assign window_event_status = upper_event_flags | lower_event_flags;
    assign masked_status = window_event_status & notify_channel_mask_bits;
    assign crc_alert     = crc_error_notify_enable & input_crc_error_flag;
    assign next_alert    = (|masked_status) | crc_alert;
    assign new_alert     = (|(masked_status & ~masked_prev)) | (crc_alert & ~crc_prev);

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            masked_prev    <= 8'h00;
            crc_prev       <= 1'b0;
            alert_internal <= 1'b0;
        end else begin
            masked_prev    <= masked_status;
            crc_prev       <= crc_alert;
            alert_internal <= next_alert;
        end
    end

    wael_pulse u_pulse (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .trigger      (new_alert),
        .pulse_active (pulse_active)
    );

    // ==========================================
    // Output shaping and channel routing
    always @* begin
        case (out_style)
            `WAEL_STYLE_ACT_LOW:    next_pin_level = ~next_alert;
            `WAEL_STYLE_ACT_HIGH:   next_pin_level = next_alert;
            `WAEL_STYLE_PULSE_LOW:  next_pin_level = ~pulse_active;
            default:                next_pin_level = pulse_active;
        endcase
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_gpio_sel <= 8'h00;
            alert_gpio_out <= 8'h00;
        end else begin
            alert_gpio_sel <= out_channel[3] ? 8'h00 : (8'h01 << out_channel[2:0]);
            alert_gpio_out <= {8{next_pin_level}};
        end
    end

    // ==========================================
    // Automatic scan sequencing
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_run     <= 1'b0;
            scan_channel <= 3'h0;
        end else begin
            scan_run <= scan_go_bit && (scan_style_field == `WAEL_SCAN_STYLE_AUTO)
                        && (scan_channel_enable_mask != 8'h00);
            if (!scan_run) begin
                scan_channel <= next_scan_ch(scan_channel_enable_mask, 3'h7);
            end else if (scan_step) begin
                scan_channel <= next_scan_ch(scan_channel_enable_mask, scan_channel);
            end
        end
    end
endmodule

// [verif/wael_chk_sva.sv]
// Concurrent checks on the ports of the alert and event logic
`timescale 1ns/1ps
module wael_chk (
    // Clock, reset, bus
    input wire       sys_clk,
    input wire       reset_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    // Events and outputs
    input wire [7:0] high_event_in,
    input wire       input_crc_error_flag,
    input wire       scan_run,
    input wire [7:0] scan_channel_enable_mask,
    input wire [7:0] alert_gpio_sel,
    input wire [7:0] alert_gpio_out,
    input wire       alert_internal
);
    reg [7:0] mask_h;
    reg [3:0] pin_h;
    reg [1:0] sty;
    reg [2:0] live;
    reg       crc_h;
    default clocking dcb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // ==========
    // Shadow of written configuration
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            {mask_h, pin_h, sty, live, crc_h} <= 18'h00000;
        end else begin
            live <= {live[1:0], 1'b1};
            if (reg_wr && reg_addr == 8'h14) mask_h <= reg_wdata;
            if (reg_wr && reg_addr == 8'h16) crc_h <= reg_wdata[0];
            if (reg_wr && reg_addr == 8'h17) {pin_h, sty} <= {reg_wdata[7:4], reg_wdata[1:0]};
        end
    end
    AST_SCAN_MASK: assert property (reg_wr && reg_addr == 8'h12
        |=> scan_channel_enable_mask == $past(reg_wdata)) else $error("scan mask");
    AST_MASK_ALERT: assert property ((high_event_in & mask_h) != 8'h00
        |-> ##[1:2] alert_internal) else $error("no alert");
    AST_QUIET: assert property ((!crc_h && mask_h == 8'h00) [*3]
        |-> !alert_internal) else $error("stray alert");
    AST_PIN_SEL: assert property (live[2] && $stable(pin_h)
        |-> alert_gpio_sel == (pin_h[3] ? 8'h00 : 8'h01 << pin_h[2:0]))
        else $error("alert select");
    AST_LEVEL: assert property (live[2] && $stable(sty) && !sty[1]
        |-> alert_gpio_out == {8{alert_internal ~^ sty[0]}}) else $error("level style");
    AST_CRC_ON: assert property (crc_h && input_crc_error_flag
        |-> ##[1:2] alert_internal) else $error("crc alert");
    AST_PULSE: assert property (sty == 2'h3 && $rose(alert_gpio_out[0])
        |=> alert_gpio_out[0] [*8] ##[1:260] !alert_gpio_out[0]) else $error("pulse");
    AST_SCAN_GO: assert property (reg_wr && reg_addr == 8'h10 && reg_wdata == 8'h11
        && scan_channel_enable_mask != 8'h00 |-> ##[1:2] scan_run) else $error("scan go");
    AST_RSVD: assert property (reg_rd && reg_addr == 8'h16
        |=> reg_rdata[7:1] == 7'h00) else $error("reserved bits");
    COV_SCAN: cover property ($rose(scan_run));
    COV_PULSE: cover property (sty == 2'h3 && $rose(alert_gpio_out[0]));
    COV_CRC: cover property (crc_h && input_crc_error_flag && alert_internal);
endmodule
bind wael_top wael_chk u_chk (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .high_event_in(high_event_in), .input_crc_error_flag(input_crc_error_flag),
    .scan_run(scan_run), .scan_channel_enable_mask(scan_channel_enable_mask),
    .alert_gpio_sel(alert_gpio_sel), .alert_gpio_out(alert_gpio_out),
    .alert_internal(alert_internal));

// [verif/wael_host.sv]
// Host model driving the register strobes
`timescale 1ns/1ps
module wael_host (
    // Clock and read data
    input  wire       sys_clk,
    input  wire [7:0] reg_rdata,
    // Register requests
    output reg  [7:0] reg_addr = 8'h00,
    output reg  [7:0] reg_wdata = 8'h00,
    output reg        reg_wr = 1'b0,
    output reg        reg_rd = 1'b0
);
    // Released lines show the inverse of their last value
    task wr(input [7:0] a, input [7:0] d);
        @(posedge sys_clk) #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(posedge sys_clk) #1 {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
    endtask
    task rd(input [7:0] a, output [7:0] v);
        @(posedge sys_clk) #1 {reg_addr, reg_rd} = {a, 1'b1};
        @(posedge sys_clk) #1 {reg_addr, reg_rd} = {~a, 1'b0};
        @(posedge sys_clk) #1 v = reg_rdata;
    endtask
endmodule

// [verif/window_alert_event_logic_tb.sv]
// Self-checking bench for the alert and event logic
`timescale 1ns/1ps
module window_alert_event_logic_tb;
    reg         sys_clk, reset_n, crc, step;
    reg  [7:0]  hi, lo, pin, dig, v, n;
    reg  [63:0] adrs = 64'h3F1C1A1817161412;
    reg  [11:0] sq = 12'h275;
    wire [7:0]  reg_addr, reg_wdata, reg_rdata, scan_mask, sel, gout;
    wire        reg_wr, reg_rd, scan_run, alert;
    wire [2:0]  scan_ch;
    integer     err_total, checks, i;
    wael_host host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
    wael_top dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .high_event_in(hi), .low_event_in(lo), .input_crc_error_flag(crc),
        .gpio_pin_in(pin), .pin_is_digital_in(dig), .scan_step(step), .scan_run(scan_run),
        .scan_channel_enable_mask(scan_mask), .scan_channel(scan_ch),
        .alert_gpio_sel(sel), .alert_gpio_out(gout), .alert_internal(alert));
    task chk(input string nm, input [7:0] exp, input [7:0] got);
        checks = checks + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask
    task rc(input string nm, input [7:0] a, input [7:0] exp);
        host.rd(a, v);
        chk(nm, exp, v);
    endtask
    task ev(input [7:0] h, input [7:0] l);
        @(posedge sys_clk) #1 {hi, lo} = {h, l};
        @(posedge sys_clk) #1 {hi, lo} = 16'h0000;
        repeat (3) @(posedge sys_clk) #1;
    endtask
    task wrap_up;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        #200000;
        err_total = err_total + 1;
        wrap_up;
    end
    initial begin
        {reset_n, crc, step, hi, lo, pin, dig} = 35'h0;
        err_total = 0;
        checks = 0;
        repeat (8) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge sys_clk) #1;
        for (i = 0; i < 8; i = i + 1) rc("reset", adrs[8*i +: 8], 8'h00);
        host.wr(8'h12, 8'hA4);
        host.wr(8'h10, 8'h11);
        repeat (2) @(posedge sys_clk) #1;
        chk("scan_run", 8'h01, {7'h0, scan_run});
        chk("scan_mask", 8'hA4, scan_mask);
        for (i = 0; i < 3; i = i + 1) begin
            @(posedge sys_clk) #1 step = 1'b1;
            @(posedge sys_clk) #1 step = 1'b0;
            chk("scan_ch", {4'h0, sq[4*i +: 4]}, {5'h0, scan_ch});
        end
        host.wr(8'h10, 8'h12);
        repeat (2) @(posedge sys_clk) #1;
        chk("scan_stop", 8'h00, {7'h0, scan_run});
        host.wr(8'h16, 8'hFF);
        rc("crc_map", 8'h16, 8'h01);
        host.wr(8'h17, 8'h2F);
        rc("out_cfg", 8'h17, 8'h23);
        host.wr(8'h16, 8'h00);
        host.wr(8'h14, 8'h04);
        host.wr(8'h17, 8'h21);
        ev(8'h02, 8'h00);
        chk("unmasked", 8'h00, gout);
        ev(8'h04, 8'h00);
        chk("alert_sel", 8'h04, sel);
        chk("alert_pin", 8'hFF, gout);
        rc("status", 8'h18, 8'h06);
        rc("upper", 8'h1A, 8'h06);
        ev(8'h00, 8'h04);
        rc("lower", 8'h1C, 8'h04);
        host.wr(8'h18, 8'hFF);
        host.wr(8'h1A, 8'h00);
        rc("upper", 8'h1A, 8'h06);
        host.wr(8'h1A, 8'h06);
        rc("status", 8'h18, 8'h04);
        host.wr(8'h1C, 8'h04);
        rc("status", 8'h18, 8'h00);
        chk("alert_clr", 8'h00, {7'h0, alert});
        host.wr(8'h16, 8'h01);
        crc = 1'b1;
        repeat (3) @(posedge sys_clk) #1;
        chk("crc_on", 8'h01, {7'h0, alert});
        crc = 1'b0;
        repeat (3) @(posedge sys_clk) #1;
        chk("crc_off", 8'h00, {7'h0, alert});
        // Let the pulse started by the CRC alert run out
        repeat (250) @(posedge sys_clk) #1;
        host.wr(8'h17, 8'h23);
        n = 8'h00;
        @(posedge sys_clk) #1 hi = 8'h04;
        @(posedge sys_clk) #1 hi = 8'h00;
        for (i = 0; i < 300; i = i + 1) begin
            @(posedge sys_clk) #1;
            if (gout[2] === 1'b1) n = n + 8'h01;
        end
        chk("pulse_len", 8'hFA, n);
        host.wr(8'h17, 8'h82);
        repeat (2) @(posedge sys_clk) #1;
        chk("no_channel", 8'h00, sel);
        chk("pulse_low_idle", 8'hFF, gout);
        host.wr(8'h1A, 8'h04);
        dig = 8'h20;
        pin = 8'h60;
        repeat (5) @(posedge sys_clk) #1;
        rc("dig_edge", 8'h1A, 8'h20);
        wrap_up;
    end
endmodule
